// File: ctsac_pkg.sv
// Package with register map, field layouts and shared types for the send-select block.
package ctsac_pkg;

    // Register byte offsets on the APB window.
    localparam logic [7:0] ABORT_DONE_OFS = 8'h00;
    localparam logic [7:0] SLOT_SEL_OFS = 8'h04;
    localparam logic [7:0] FILTER_CTRL_OFS = 8'h08;
    localparam logic [7:0] FACTORY_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] SLOT_FLAG_OFS = 8'h18;
    localparam logic [7:0] ABORT_REQ_OFS = 8'h1c;
    localparam logic [7:0] MODE_OFS = 8'h20;
    localparam logic [7:0] WIN_BASE_OFS = 8'h40;
    localparam logic [7:0] WIN_END_OFS = 8'h7c;

    // Field positions.
    localparam int LAYOUT_LSB = 4;
    localparam int HIT_LSB = 0;
    localparam int MODE_REQ_BIT = 0;
    localparam int MODE_ACK_BIT = 1;

    // Reset values.
    localparam logic [2:0] SLOTS_RST = 3'h0;
    localparam logic [2:0] FLAGS_RST = 3'h7;
    localparam logic [1:0] LAYOUT_RST = 2'h0;
    localparam logic [2:0] HIT_RST = 3'h0;

    // Number of words in each buffer window.
    localparam int WIN_WORDS = 16;

    // Interrupt status bit positions.
    localparam int IRQ_FREE_LSB = 0;
    localparam int IRQ_ABORT_LSB = 3;
    localparam int IRQ_REFUSE_BIT = 6;
    localparam int IRQ_W = 7;

    // Acceptance filter layouts.
    typedef enum logic [1:0] {
        CTSAC_TWO32 = 2'h0,
        CTSAC_FOUR16 = 2'h1,
        CTSAC_EIGHT8 = 2'h2,
        CTSAC_CLOSED = 2'h3
    } ctsac_layout_t;

endpackage : ctsac_pkg

// File: ctsac_win_if.sv
// Interface carrying window accesses between the register file and the buffer store.
`timescale 1ns/1ns
interface ctsac_win_if;
    logic wr;
    logic [1:0] slot;
    logic [3:0] word;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport ctrl (output wr, output slot, output word, output wdata, input rdata);
    modport store (input wr, input slot, input word, input wdata, output rdata);
endinterface : ctsac_win_if

// File: ctsac_buf_store.sv
// Storage for the three transmit buffers behind the shared window.
`timescale 1ns/1ns
module ctsac_buf_store #(
    parameter int WORDS = ctsac_pkg::WIN_WORDS
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Window access.
    ctsac_win_if.store win
);

    logic [31:0] mem_r [0:3*WORDS-1];
    logic [31:0] rdata_r;

    // Flat index of a slot and word.
    function automatic int unsigned flat_idx(input logic [1:0] s, input logic [3:0] w);
        flat_idx = unsigned'(int'(s) * WORDS + int'(w));
    endfunction : flat_idx

    // Writes land in the array; no reset so the store maps to RAM.
    always_ff @(posedge core_clk) begin
        if (win.wr) begin
            mem_r[flat_idx(win.slot, win.word)] <= win.wdata;
        end
    end

    // Registered read port; data is valid one cycle after the address.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= mem_r[flat_idx(win.slot, win.word)];
        end
    end

    assign win.rdata = rdata_r;

endmodule : ctsac_buf_store

// File: ctsac_ctrl.sv
// Transmit buffer select, abort acknowledge and acceptance control register block.
//
// Overview of operation
// - Abort-done flags held at reset while init mode is requested and acknowledged.
// - Abort-done bit reads 1 when its message was aborted, else 0.
// - Software clearing a slot free flag clears its abort-done bit too.
// - Only the lowest-numbered selected slot is mapped into the window.
// - Slot select reads back only its lowest set bit.
// - Slot select held at reset in init; writable only when request and ack clear.
// - Window access blocked while selected slot is scheduled for sending.
// - With no slot selected every window access is refused.
// - Layout field: 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - With the filter closed no message is accepted into the front buffer.
// - Match index gives the number 0 to 7 of the matching filter.
// - Match index follows the front buffer; updated on each shift in unless the filter is closed.
// - Filter control writable only in init mode; match index always read-only.
// - Factory register reads zero and ignores writes in normal modes.
// - Granted abort sets free flag and abort-done bit, raising interrupt if enabled.
`timescale 1ns/1ns
module ctsac_ctrl (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit engine events.
    input wire logic tx_sent_ok,
    input wire logic [1:0] tx_sent_slot,
    input wire logic tx_abort_grant,
    input wire logic [1:0] tx_abort_slot,
    output logic [2:0] tx_scheduled,
    output logic [2:0] abort_request_bit,
    // Receive path.
    input wire logic rx_front_load,
    input wire logic [2:0] rx_front_hit,
    input wire logic rx_candidate,
    output logic rx_accept,
    output logic [1:0] filter_layout_sel,
    output logic [3:0] filter_count,
    output logic [5:0] filter_width,
    // Interrupt.
    output logic irq
);

    ctsac_win_if win ();

    ctsac_buf_store u_store (
        .core_clk(core_clk),
        .nrst(nrst),
        .win(win)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode and register state.

    logic init_request_r;
    logic init_ack_r;
    logic in_init;
    logic not_init;
    logic [2:0] send_slot_free_r;
    logic [2:0] abort_done_bit_r;
    logic [2:0] abort_req_r;
    logic [2:0] slot_sel_r;
    logic [1:0] layout_r;
    logic [2:0] hit_r;
    logic [ctsac_pkg::IRQ_W-1:0] irq_stat_r;
    logic [ctsac_pkg::IRQ_W-1:0] irq_mask_r;
    logic [31:0] prdata_r;
    logic rd_pend_r;
    logic slverr_r;

    // Lowest set bit of a three-bit vector, one-hot.
    function automatic logic [2:0] lowest_bit(input logic [2:0] v);
        lowest_bit = v & (~v + 3'h1);
    endfunction : lowest_bit

    // Slot number of a one-hot vector.
    function automatic logic [1:0] slot_num(input logic [2:0] oh);
        slot_num = oh[0] ? 2'h0 : (oh[1] ? 2'h1 : 2'h2);
    endfunction : slot_num

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic acc;
    logic wr_en;
    logic [2:0] sel_oh;
    logic win_hit;
    logic win_ok;
    logic mapped;
    logic [2:0] clr_free;
    logic [2:0] sent_oh;
    logic [2:0] abort_oh;

    // Setup cycle starts the access; permitted window reads need one extra wait cycle.
    assign acc = psel && penable;
    assign wr_en = acc && pwrite && pready;
    assign in_init = init_request_r && init_ack_r;
    assign not_init = !init_request_r && !init_ack_r;
    assign sel_oh = lowest_bit(slot_sel_r);
    assign win_hit = (paddr >= ctsac_pkg::WIN_BASE_OFS) && (paddr <= ctsac_pkg::WIN_END_OFS);
    // A scheduled slot is locked; no selection means no window at all.
    assign win_ok = (sel_oh != 3'h0) && ((sel_oh & send_slot_free_r) != 3'h0);
    assign mapped = (paddr == ctsac_pkg::ABORT_DONE_OFS) || (paddr == ctsac_pkg::SLOT_SEL_OFS)
        || (paddr == ctsac_pkg::FILTER_CTRL_OFS) || (paddr == ctsac_pkg::FACTORY_OFS)
        || (paddr == ctsac_pkg::IRQ_STAT_OFS) || (paddr == ctsac_pkg::IRQ_MASK_OFS)
        || (paddr == ctsac_pkg::SLOT_FLAG_OFS) || (paddr == ctsac_pkg::ABORT_REQ_OFS)
        || (paddr == ctsac_pkg::MODE_OFS) || win_hit;
    assign pready = !(acc && !pwrite && win_hit && win_ok && !rd_pend_r);
    assign pslverr = slverr_r;
    assign prdata = prdata_r;

    // Window port to the buffer store.
    assign win.wr = wr_en && win_hit && win_ok;
    assign win.slot = slot_num(sel_oh);
    assign win.word = paddr[5:2];
    assign win.wdata = pwdata;

    // One wait cycle for the registered store read.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= acc && !pwrite && win_hit && !pready;
        end
    end

    // Error response is never given; pslverr stays 0 and refusals set an interrupt status bit instead.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slverr_r <= 1'b0;
        end else begin
            slverr_r <= acc && !pready ? 1'b0 : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initialization mode; the acknowledge follows the request one cycle later.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            init_request_r <= 1'b1;
            init_ack_r <= 1'b0;
        end else begin
            if (wr_en && paddr == ctsac_pkg::MODE_OFS) begin
                init_request_r <= pwdata[ctsac_pkg::MODE_REQ_BIT];
            end
            init_ack_r <= init_request_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot free flags; software clears by writing one, engine sets on completion.

    assign clr_free = (wr_en && paddr == ctsac_pkg::SLOT_FLAG_OFS && not_init)
        ? pwdata[2:0] : 3'h0;
    assign sent_oh = tx_sent_ok ? (3'h1 << tx_sent_slot) : 3'h0;
    assign abort_oh = (tx_abort_grant && (abort_req_r[tx_abort_slot])) ? (3'h1 << tx_abort_slot)
        : 3'h0;
    assign tx_scheduled = ~send_slot_free_r;
    assign abort_request_bit = abort_req_r;

    // Set beats clear so a completion in the clearing cycle is not lost.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            send_slot_free_r <= ctsac_pkg::FLAGS_RST;
        end else if (in_init) begin
            send_slot_free_r <= ctsac_pkg::FLAGS_RST;
        end else begin
            send_slot_free_r <= (send_slot_free_r & ~clr_free) | sent_oh | abort_oh;
        end
    end

    // Abort requests: software sets, cleared once the slot is free again.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            abort_req_r <= 3'h0;
        end else if (in_init) begin
            abort_req_r <= 3'h0;
        end else begin
            abort_req_r <= (abort_req_r | ((wr_en && paddr == ctsac_pkg::ABORT_REQ_OFS
                && not_init) ? pwdata[2:0] & ~send_slot_free_r : 3'h0))
                & ~(sent_oh | abort_oh);
        end
    end

    // Abort-done bits; bus writes to this offset are ignored.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            abort_done_bit_r <= 3'h0;
        end else if (in_init) begin
            abort_done_bit_r <= 3'h0;
        end else begin
            // A normal send leaves the bit clear; only a granted abort sets it.
            abort_done_bit_r <= ((abort_done_bit_r & ~clr_free) & ~sent_oh) | abort_oh;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot select register.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slot_sel_r <= ctsac_pkg::SLOTS_RST;
        end else if (in_init) begin
            slot_sel_r <= ctsac_pkg::SLOTS_RST;
        end else if (wr_en && paddr == ctsac_pkg::SLOT_SEL_OFS && not_init) begin
            slot_sel_r <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance control: layout writable in init only, match index by hardware.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            layout_r <= ctsac_pkg::LAYOUT_RST;
        end else if (wr_en && paddr == ctsac_pkg::FILTER_CTRL_OFS && in_init) begin
            layout_r <= pwdata[ctsac_pkg::LAYOUT_LSB +: 2];
        end
    end

    // Index follows whatever moves into the front buffer while the filter is not closed.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hit_r <= ctsac_pkg::HIT_RST;
        end else if (rx_front_load && layout_r != ctsac_pkg::CTSAC_CLOSED) begin
            hit_r <= rx_front_hit;
        end
    end

    assign filter_layout_sel = layout_r;
    assign rx_accept = rx_candidate && (layout_r != ctsac_pkg::CTSAC_CLOSED);

    // Filter organisation for the matcher.
    always_comb begin
        case (ctsac_pkg::ctsac_layout_t'(layout_r))
            ctsac_pkg::CTSAC_TWO32: begin
                filter_count = 4'h2;
                filter_width = 6'h20;
            end
            ctsac_pkg::CTSAC_FOUR16: begin
                filter_count = 4'h4;
                filter_width = 6'h10;
            end
            ctsac_pkg::CTSAC_EIGHT8: begin
                filter_count = 4'h8;
                filter_width = 6'h08;
            end
            default: begin
                filter_count = 4'h0;
                filter_width = 6'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, write one to clear, set wins over clear.

    logic [ctsac_pkg::IRQ_W-1:0] irq_set;
    logic [ctsac_pkg::IRQ_W-1:0] irq_clr;

    assign irq_set = {acc && pready && (!mapped || (win_hit && !win_ok)), abort_oh,
        sent_oh | abort_oh};
    assign irq_clr = (wr_en && paddr == ctsac_pkg::IRQ_STAT_OFS)
        ? pwdata[ctsac_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_r <= '0;
        end else if (wr_en && paddr == ctsac_pkg::IRQ_MASK_OFS) begin
            irq_mask_r <= pwdata[ctsac_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read data; the factory register always reads zero.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ctsac_pkg::ABORT_DONE_OFS) begin
                prdata_r <= {29'h0, abort_done_bit_r};
            end else if (paddr == ctsac_pkg::SLOT_SEL_OFS) begin
                prdata_r <= {29'h0, sel_oh};
            end else if (paddr == ctsac_pkg::FILTER_CTRL_OFS) begin
                prdata_r <= {26'h0, layout_r, 1'b0, hit_r};
            end else if (paddr == ctsac_pkg::IRQ_STAT_OFS) begin
                prdata_r <= {25'h0, irq_stat_r};
            end else if (paddr == ctsac_pkg::IRQ_MASK_OFS) begin
                prdata_r <= {25'h0, irq_mask_r};
            end else if (paddr == ctsac_pkg::SLOT_FLAG_OFS) begin
                prdata_r <= {29'h0, send_slot_free_r};
            end else if (paddr == ctsac_pkg::ABORT_REQ_OFS) begin
                prdata_r <= {29'h0, abort_req_r};
            end else if (paddr == ctsac_pkg::MODE_OFS) begin
                prdata_r <= {30'h0, init_ack_r, init_request_r};
            end else begin
                prdata_r <= 32'h0;
            end
        end else if (acc && !pwrite && win_hit && !pready) begin
            // Taken in the wait cycle so the word stands when pready rises.
            prdata_r <= win.rdata;
        end
    end

endmodule : ctsac_ctrl

// File: ctsac_ctrl_monitor.sv
// Port-level checker for the send-select and acceptance control block.
`timescale 1ns/1ns
module ctsac_ctrl_monitor (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Transmit engine.
    input wire logic tx_sent_ok,
    input wire logic [1:0] tx_sent_slot,
    input wire logic tx_abort_grant,
    input wire logic [1:0] tx_abort_slot,
    input wire logic [2:0] tx_scheduled,
    input wire logic [2:0] abort_request_bit,
    // Receive path.
    input wire logic rx_candidate,
    input wire logic rx_accept,
    input wire logic [1:0] filter_layout_sel,
    input wire logic [3:0] filter_count,
    input wire logic [5:0] filter_width
);
    logic req_r;
    logic ack_r;
    logic init_w;
    ////////////////////////////////
    // Mirror of the mode bits, because init state is not visible at the ports.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_r <= 1'b1;
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_r;
            if (psel && penable && pready && pwrite && paddr == ctsac_pkg::MODE_OFS) begin
                req_r <= pwdata[ctsac_pkg::MODE_REQ_BIT];
            end
        end
    end
    // Init mode needs both bits.
    assign init_w = req_r && ack_r;
    ////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Phases of one bus transfer.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_write_fast: assert property (s_setup ##0 pwrite |=> pready)
        else $error("write not ready in first access cycle");
    a_wait_bounded: assert property (s_access ##0 !pready |=> pready)
        else $error("access phase waits too long");
    a_no_slverr: assert property (s_access |-> !pslverr)
        else $error("refusal reported as slave error");
    a_layout_decode: assert property (filter_count == (filter_layout_sel == 2'h3 ? 4'h0 :
        4'h2 << filter_layout_sel) && filter_width == (filter_layout_sel == 2'h3 ? 6'h00 :
        6'h20 >> filter_layout_sel)) else $error("layout decode wrong");
    a_accept_gate: assert property (rx_accept == (rx_candidate && filter_layout_sel != 2'h3))
        else $error("accept not gated by closed filter");
    a_layout_frozen: assert property ($changed(filter_layout_sel) |-> $past(init_w))
        else $error("layout changed outside init mode");
    a_abort_frees: assert property (tx_abort_grant && abort_request_bit[tx_abort_slot] |=>
        !tx_scheduled[$past(tx_abort_slot)] && !abort_request_bit[$past(tx_abort_slot)])
        else $error("granted abort did not free slot");
    a_sent_frees: assert property (tx_sent_ok |=> !tx_scheduled[$past(tx_sent_slot)])
        else $error("sent slot not freed");
    a_req_on_sched: assert property ((abort_request_bit & ~tx_scheduled) == 3'h0)
        else $error("abort request on a free slot");
endmodule : ctsac_ctrl_monitor

bind ctsac_ctrl ctsac_ctrl_monitor u_mon (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .tx_sent_ok, .tx_sent_slot, .tx_abort_grant, .tx_abort_slot,
    .tx_scheduled, .abort_request_bit, .rx_candidate, .rx_accept, .filter_layout_sel,
    .filter_count, .filter_width);

// File: ctsac_node_model.sv
// Behavioural model of the transmit engine that faces the block.
`timescale 1ns/1ns
module ctsac_node_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Bench commands.
    input wire logic send_cmd,
    input wire logic [1:0] send_slot,
    input wire logic [3:0] abort_lag,
    // Block side.
    input wire logic [2:0] tx_scheduled,
    input wire logic [2:0] abort_request_bit,
    output logic tx_sent_ok,
    output logic [1:0] tx_sent_slot,
    output logic tx_abort_grant,
    output logic [1:0] tx_abort_slot
);
    logic [2:0] pend;
    logic [3:0] lag_r;
    assign pend = abort_request_bit & tx_scheduled;
    ////////////////////////////////
    // Grants the lowest pending abort after a chosen lag, so slow answers are exercised too.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sent_ok <= 1'b0;
            tx_sent_slot <= 2'h0;
            tx_abort_grant <= 1'b0;
            tx_abort_slot <= 2'h0;
            lag_r <= 4'h0;
        end else begin
            tx_sent_ok <= send_cmd;
            tx_sent_slot <= send_slot;
            tx_abort_grant <= 1'b0;
            lag_r <= 4'h0;
            if (pend != 3'h0 && !tx_abort_grant) begin
                lag_r <= lag_r + 4'h1;
                if (lag_r == abort_lag) begin
                    tx_abort_grant <= 1'b1;
                    tx_abort_slot <= pend[0] ? 2'h0 : (pend[1] ? 2'h1 : 2'h2);
                    lag_r <= 4'h0;
                end
            end
        end
    end
endmodule : ctsac_node_model

// File: can_tx_select_and_accept_ctrl_bench.sv
// Self-checking bench for the send-select and acceptance control block.
`timescale 1ns/1ns
module can_tx_select_and_accept_ctrl_bench;
    localparam logic [7:0] A_AD = ctsac_pkg::ABORT_DONE_OFS;
    localparam logic [7:0] A_SEL = ctsac_pkg::SLOT_SEL_OFS;
    localparam logic [7:0] A_FC = ctsac_pkg::FILTER_CTRL_OFS;
    localparam logic [7:0] A_FL = ctsac_pkg::SLOT_FLAG_OFS;
    localparam logic [7:0] A_IS = ctsac_pkg::IRQ_STAT_OFS;
    localparam logic [7:0] A_IM = ctsac_pkg::IRQ_MASK_OFS;
    localparam logic [7:0] A_WIN = ctsac_pkg::WIN_BASE_OFS;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic send_cmd = 1'b0;
    logic [1:0] send_slot = 2'h0;
    logic [3:0] abort_lag = 4'h0;
    logic rx_front_load = 1'b0;
    logic [2:0] rx_front_hit = 3'h0;
    logic rx_candidate = 1'b0;
    logic tx_sent_ok, tx_abort_grant, rx_accept, irq;
    logic [1:0] tx_sent_slot, tx_abort_slot;
    logic [2:0] tx_scheduled, abort_request_bit;
    logic [31:0] rd;
    int n_fail = 0;
    int total_checks = 0;
    ////////////////////////////////
    // Design and the engine model facing it.
    ctsac_ctrl dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr(), .tx_sent_ok, .tx_sent_slot, .tx_abort_grant, .tx_abort_slot,
        .tx_scheduled, .abort_request_bit, .rx_front_load, .rx_front_hit, .rx_candidate,
        .rx_accept, .filter_layout_sel(), .filter_count(), .filter_width(), .irq);
    ctsac_node_model u_node (.core_clk, .nrst, .send_cmd, .send_slot, .abort_lag,
        .tx_scheduled, .abort_request_bit, .tx_sent_ok, .tx_sent_slot, .tx_abort_grant,
        .tx_abort_slot);
    // Free-running 20 MHz clock.
    always #25 core_clk = ~core_clk;
    ////////////////////////////////
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // One APB transfer; pready and read data are taken at the rising edge that ends it.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    // Register read compared with an expected word.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask : rdc
    // Moves a message with its filter index into the front buffer.
    task automatic load(input logic [2:0] h);
        rx_front_hit <= h;
        rx_front_load <= 1'b1;
        @(posedge core_clk);
        rx_front_load <= 1'b0;
    endtask : load
    // Waits, bounded, until the engine has freed every slot.
    task automatic wait_free();
        int n;
        n = 0;
        while (tx_scheduled !== 3'h0 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 40) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wait_free
    ////////////////////////////////
    // Main sequence: init-mode checks first, then normal-mode traffic.
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rdc(A_FL, 32'h7);
        rdc(A_AD, 32'h0);
        wr(A_SEL, 32'h1);
        rdc(A_SEL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(A_FC, 32'(i << 4) | 32'h7);
            rdc(A_FC, 32'(i << 4));
        end
        rx_candidate <= 1'b1;
        load(3'h5);
        @(negedge core_clk);
        chk(rx_accept, 32'h0);
        rdc(A_FC, 32'h30);
        wr(A_FC, 32'h20);
        wr(ctsac_pkg::MODE_OFS, 32'h0);
        wr(A_FC, 32'h10);
        rdc(A_FC, 32'h20);
        for (int i = 0; i < 8; i++) begin
            load(3'(i));
            rdc(A_FC, 32'h20 | 32'(i));
        end
        chk(rx_accept, 32'h1);
        wr(ctsac_pkg::FACTORY_OFS, 32'hffffffff);
        rdc(ctsac_pkg::FACTORY_OFS, 32'h0);
        wr(A_WIN, 32'h000000a5);
        rdc(A_WIN, 32'h0);
        rdc(A_FL, 32'h7);
        wr(A_SEL, rd);
        rdc(A_SEL, 32'h1);
        wr(A_SEL, 32'h6);
        rdc(A_SEL, 32'h2);
        wr(A_WIN, 32'h11110001);
        wr(A_SEL, 32'h4);
        wr(A_WIN, 32'h22220002);
        rdc(A_WIN, 32'h22220002);
        wr(A_SEL, 32'h2);
        rdc(A_WIN, 32'h11110001);
        wr(A_FL, 32'h2);
        rdc(A_FL, 32'h5);
        wr(A_WIN, 32'h00000033);
        rdc(A_WIN, 32'h0);
        wr(A_IS, 32'h7f);
        wr(A_IM, 32'h10);
        wr(ctsac_pkg::ABORT_REQ_OFS, 32'h2);
        wait_free();
        rdc(A_AD, 32'h2);
        rdc(A_IS, 32'h12);
        @(negedge core_clk);
        chk(irq, 32'h1);
        wr(A_IS, 32'h12);
        @(negedge core_clk);
        chk(irq, 32'h0);
        rdc(A_WIN, 32'h11110001);
        wr(A_AD, 32'h0);
        rdc(A_AD, 32'h2);
        wr(A_FL, 32'h2);
        rdc(A_AD, 32'h0);
        send_slot <= 2'h1;
        send_cmd <= 1'b1;
        @(posedge core_clk);
        send_cmd <= 1'b0;
        wait_free();
        rdc(A_AD, 32'h0);
        abort_lag <= 4'h5;
        wr(A_FL, 32'h1);
        wr(ctsac_pkg::ABORT_REQ_OFS, 32'h1);
        wait_free();
        rdc(A_AD, 32'h1);
        wr(ctsac_pkg::MODE_OFS, 32'h1);
        rdc(ctsac_pkg::MODE_OFS, 32'h3);
        rdc(A_AD, 32'h0);
        rdc(A_SEL, 32'h0);
        tally_and_finish();
    end
endmodule : can_tx_select_and_accept_ctrl_bench
